/* rtl/clk_out_if.sv */
// Purpose: bundle between the register file and one external clock output channel
// Assumes: single clock domain, oscillator levels already synchronous
// Notes: osc_level bit order follows the source codes
`timescale 1ns/1ps
interface clk_out_if;
  logic [2:0] osc_level;
  clkgen_pkg::clock_source_t source;
  clkgen_pkg::clock_divider_t divider;
  logic enable;
  logic out;
  modport channel(input osc_level, input source, input divider, input enable, output out);
  modport control(output osc_level, output source, output divider, output enable, input out);
endinterface

/* rtl/clkgen_pkg.sv */
// Purpose: shared constants and types for the clock generator output and gating block
// Assumes: registers are byte wide, one per aligned APB word at four times the index
// Notes: indices are kept as printed; byte addresses are derived from them
package clkgen_pkg;

  // register indices and derived byte addresses
  localparam int INDEX_SHIFT = 2;
  localparam logic [31:0] SLEEP_CTRL_INDEX = 32'h0000_5062;
  localparam logic [31:0] CLOCK_OUT_A_INDEX = 32'h0000_5064;
  localparam logic [31:0] CLOCK_OUT_B_INDEX = 32'h0000_5065;
  localparam logic [31:0] PCLK_GATE_INDEX = 32'h0000_5080;
  localparam logic [31:0] CORE_GEAR_INDEX = 32'h0000_5081;
  localparam logic [31:0] SLEEP_CTRL_ADDR = SLEEP_CTRL_INDEX << INDEX_SHIFT;
  localparam logic [31:0] CLOCK_OUT_A_ADDR = CLOCK_OUT_A_INDEX << INDEX_SHIFT;
  localparam logic [31:0] CLOCK_OUT_B_ADDR = CLOCK_OUT_B_INDEX << INDEX_SHIFT;
  localparam logic [31:0] PCLK_GATE_ADDR = PCLK_GATE_INDEX << INDEX_SHIFT;
  localparam logic [31:0] CORE_GEAR_ADDR = CORE_GEAR_INDEX << INDEX_SHIFT;

  // field positions
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_SRC_LSB = 2;
  localparam int OUT_DIV_LSB = 4;
  localparam int SLEEP_HIGH_BIT = 4;
  localparam int SLEEP_LOW_BIT = 5;
  localparam int SLEEP_INT_BIT = 6;
  localparam int SLEEP_ONE_BIT = 1;

  // reset values
  localparam logic SLEEP_STOP_RESET = 1'b1;
  localparam logic OUT_EN_RESET = 1'b0;
  localparam logic [1:0] PCLK_GATE_RESET = 2'h3;
  localparam logic [1:0] CORE_GEAR_RESET = 2'h0;
  localparam logic [2:0] GEAR_COUNT_RESET = 3'h0;

  // peripheral clock gate codes
  localparam logic [1:0] PCLK_ON = 2'h3;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_LOW_SPEED = 2'b01,
    SRC_HIGH_SPEED = 2'b10,
    SRC_RESERVED = 2'b11
  } clock_source_t;

  typedef enum logic [1:0] {
    DIV_1 = 2'b00,
    DIV_2 = 2'b01,
    DIV_4 = 2'b10,
    DIV_RESERVED = 2'b11
  } clock_divider_t;

endpackage

/* rtl/clock_gen_output_gating.sv */
// Purpose: sleep stop control, two clock outputs, peripheral clock gate and core gear
// Assumes: APB slave, zero wait states; oscillator clocks arrive as sampled levels
// Notes: ce_i low freezes every flop and holds pready low
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Summary of operation
// - low-speed oscillator stops in sleep if set
// - high-speed oscillator stops in sleep if set
// - output A divider 1, 2, 4
// - output A low-speed source bypasses divider
// - output A source internal, low, high
// - output A enable drives pin
// - output B divider 1, 2, 4
// - output B low-speed source bypasses divider
// - output B source internal, low, high
// - output B enable drives pin
// - peripheral gate 3 on, 0 off
// - outputs keep running with peripheral clock off
// - core clock gear divides 1, 2, 4, 8
// - internal oscillator stops in sleep if set
// - wake restores state, internal oscillator selected
module clock_gen_output_gating (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_i,
  input wire logic internal_osc_enable_i,
  input wire logic low_speed_osc_enable_i,
  input wire logic high_speed_osc_enable_i,
  input wire logic internal_osc_clk_i,
  input wire logic low_speed_osc_clk_i,
  input wire logic high_speed_osc_clk_i,
  output logic internal_osc_run_o,
  output logic low_speed_osc_run_o,
  output logic high_speed_osc_run_o,
  output logic wake_internal_osc_on_o,
  output logic wake_select_internal_o,
  output logic clock_out_a_o,
  output logic clock_out_b_o,
  output logic [1:0] peripheral_clock_group_o,
  output logic peripheral_clock_on_o,
  output logic core_clock_enable_o
);

  logic internal_osc_sleep_stop;
  logic low_speed_osc_sleep_stop;
  logic high_speed_osc_sleep_stop;
  logic [1:0] peripheral_clock_gate_field;
  logic [1:0] core_clock_gear_field;
  logic [2:0] gear_count;
  logic prev_sleep;
  logic [1:0] chan_out;
  logic [1:0] out_src [2];
  logic [1:0] out_div [2];
  logic out_en [2];
  logic [7:0] out_ctrl_read [2];

  // bus phases and address decode
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i & ce_i;
  wire lane0 = pstrb_i[0];
  wire wr_access = access & pwrite_i & lane0;
  wire hit_sleep = paddr_i == clkgen_pkg::SLEEP_CTRL_ADDR;
  wire hit_a = paddr_i == clkgen_pkg::CLOCK_OUT_A_ADDR;
  wire hit_b = paddr_i == clkgen_pkg::CLOCK_OUT_B_ADDR;
  wire hit_gate = paddr_i == clkgen_pkg::PCLK_GATE_ADDR;
  wire hit_gear = paddr_i == clkgen_pkg::CORE_GEAR_ADDR;
  wire mapped = hit_sleep | hit_a | hit_b | hit_gate | hit_gear;
  wire [1:0] hit_out = {hit_b, hit_a};

  // write strobes per register
  wire wr_sleep = wr_access & hit_sleep;
  wire wr_gate = wr_access & hit_gate;
  wire wr_gear = wr_access & hit_gear;

  // zero wait state answer; unmapped addresses answer with an error
  assign pready_o = ce_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // read images; unused bits read zero, bit 1 of sleep control reads one
  wire [7:0] sleep_read = {1'b0, internal_osc_sleep_stop, low_speed_osc_sleep_stop,
                           high_speed_osc_sleep_stop, 2'b00, 1'b1, 1'b0};
  wire [7:0] gate_read = {6'h00, peripheral_clock_gate_field};
  wire [7:0] gear_read = {6'h00, core_clock_gear_field};
  wire [7:0] read_byte = hit_sleep ? sleep_read :
                         hit_a ? out_ctrl_read[0] :
                         hit_b ? out_ctrl_read[1] :
                         hit_gate ? gate_read :
                         hit_gear ? gear_read : 8'h00;

  // read data captured in the setup cycle, held through the access phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (ce_i && setup) begin
      prdata_o <= {24'h00_0000, read_byte};
    end
  end

  // sleep stop control bits
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      internal_osc_sleep_stop <= clkgen_pkg::SLEEP_STOP_RESET;
      low_speed_osc_sleep_stop <= clkgen_pkg::SLEEP_STOP_RESET;
      high_speed_osc_sleep_stop <= clkgen_pkg::SLEEP_STOP_RESET;
    end else if (wr_sleep) begin
      internal_osc_sleep_stop <= pwdata_i[clkgen_pkg::SLEEP_INT_BIT];
      low_speed_osc_sleep_stop <= pwdata_i[clkgen_pkg::SLEEP_LOW_BIT];
      high_speed_osc_sleep_stop <= pwdata_i[clkgen_pkg::SLEEP_HIGH_BIT];
    end
  end

  // sleep exit edge
  wire wake = prev_sleep & ~sleep_i;
  wire next_low_run = low_speed_osc_enable_i & ~(sleep_i & low_speed_osc_sleep_stop);
  wire next_high_run = high_speed_osc_enable_i & ~(sleep_i & high_speed_osc_sleep_stop);
  wire next_int_run = (internal_osc_enable_i & ~(sleep_i & internal_osc_sleep_stop)) | wake;

  // oscillator run requests and wake pulses
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_sleep <= 1'b0;
      internal_osc_run_o <= 1'b1;
      low_speed_osc_run_o <= 1'b0;
      high_speed_osc_run_o <= 1'b0;
      wake_internal_osc_on_o <= 1'b0;
      wake_select_internal_o <= 1'b0;
    end else if (ce_i) begin
      prev_sleep <= sleep_i;
      internal_osc_run_o <= next_int_run;
      low_speed_osc_run_o <= next_low_run;
      high_speed_osc_run_o <= next_high_run;
      wake_internal_osc_on_o <= wake;
      wake_select_internal_o <= wake;
    end
  end

  // both clock output channels: register, interface and channel logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : chan
      clk_out_if link ();
      wire wr_this = wr_access & hit_out[ch];

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          out_src[ch] <= clkgen_pkg::SRC_INTERNAL;
          out_div[ch] <= clkgen_pkg::DIV_1;
          out_en[ch] <= clkgen_pkg::OUT_EN_RESET;
        end else if (wr_this) begin
          out_src[ch] <= pwdata_i[clkgen_pkg::OUT_SRC_LSB +: 2];
          out_div[ch] <= pwdata_i[clkgen_pkg::OUT_DIV_LSB +: 2];
          out_en[ch] <= pwdata_i[clkgen_pkg::OUT_EN_BIT];
        end
      end

      assign out_ctrl_read[ch] = {2'b00, out_div[ch], out_src[ch], 1'b0, out_en[ch]};
      assign link.osc_level = {high_speed_osc_clk_i, low_speed_osc_clk_i, internal_osc_clk_i};
      assign link.source = clkgen_pkg::clock_source_t'(out_src[ch]);
      assign link.divider = clkgen_pkg::clock_divider_t'(out_div[ch]);
      assign link.enable = out_en[ch];
      assign chan_out[ch] = link.out;

      clock_out_channel unit (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .port(link.channel)
      );
    end
  endgenerate

  assign clock_out_a_o = chan_out[0];
  assign clock_out_b_o = chan_out[1];

  // peripheral clock gate and core gear fields
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      peripheral_clock_gate_field <= clkgen_pkg::PCLK_GATE_RESET;
      core_clock_gear_field <= clkgen_pkg::CORE_GEAR_RESET;
    end else begin
      if (wr_gate) begin
        peripheral_clock_gate_field <= pwdata_i[1:0];
      end
      if (wr_gear) begin
        core_clock_gear_field <= pwdata_i[1:0];
      end
    end
  end

  // gate field supplies clock
  // each bit feeds one group, so the prohibited codes halt only part
  assign peripheral_clock_group_o = peripheral_clock_gate_field;
  assign peripheral_clock_on_o = peripheral_clock_gate_field == clkgen_pkg::PCLK_ON;

  wire [2:0] gear_mask = (core_clock_gear_field == 2'h0) ? 3'h0 :
                         (core_clock_gear_field == 2'h1) ? 3'h1 :
                         (core_clock_gear_field == 2'h2) ? 3'h3 : 3'h7;
  wire [2:0] next_gear_count = 3'(gear_count + 3'h1);
  wire gear_tick = (gear_count & gear_mask) == 3'h0;

  // free running gear counter and core clock enable pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gear_count <= clkgen_pkg::GEAR_COUNT_RESET;
      core_clock_enable_o <= 1'b0;
    end else if (ce_i) begin
      gear_count <= next_gear_count;
      core_clock_enable_o <= gear_tick;
    end
  end

endmodule

/* rtl/clock_out_channel.sv */
// Purpose: one external clock output with source select, divider and glitch-free enable
// Assumes: oscillator levels are sampled on clock_i, well below half its rate
// Notes: new settings are taken only while the pin is low at a phase boundary
`timescale 1ns/1ps
module clock_out_channel (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  clk_out_if.channel port
);

  clkgen_pkg::clock_source_t active_src;
  clkgen_pkg::clock_divider_t active_div;
  logic active_en;
  logic prev_level;
  logic half_count;
  logic out;

  // selected source level and its rising edge
  wire level = (active_src == clkgen_pkg::SRC_RESERVED) ? 1'b0 : port.osc_level[active_src];
  wire rise = level & ~prev_level;
  wire undivided = (active_src == clkgen_pkg::SRC_LOW_SPEED) ||
                   (active_div == clkgen_pkg::DIV_1) ||
                   (active_div == clkgen_pkg::DIV_RESERVED);
  wire last_edge = (active_div == clkgen_pkg::DIV_2) | half_count;
  wire may_reload = ~out & (~active_en | (undivided ? ~level : (~rise & ~half_count)));

  // settings shadow, edge counting and pin drive
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      active_src <= clkgen_pkg::SRC_INTERNAL;
      active_div <= clkgen_pkg::DIV_1;
      active_en <= clkgen_pkg::OUT_EN_RESET;
      prev_level <= 1'b0;
      half_count <= 1'b0;
      out <= 1'b0;
    end else if (ce_i) begin
      prev_level <= level;
      if (may_reload) begin
        active_src <= port.source;
        active_div <= port.divider;
        active_en <= port.enable;
        half_count <= 1'b0;
        out <= 1'b0;
      end else if (!active_en) begin
        out <= 1'b0; // static low while disabled
      end else if (undivided) begin
        // high pulses start only on a source edge
        out <= rise | (out & level);
      end else if (rise) begin
        if (last_edge) begin
          out <= ~out;
          half_count <= 1'b0;
        end else begin
          half_count <= 1'b1;
        end
      end
    end
  end

  assign port.out = out;

endmodule

/* verification/clock_gen_output_gating_monitor.sv */
// Purpose: port-level assertions for the clock generator block
// Assumes: single clock domain, synchronous active high reset
// Notes: attached to the top module by bind
`timescale 1ns/1ps
module clock_gen_output_gating_monitor (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sleep_i,
  input wire logic internal_osc_enable_i,
  input wire logic low_speed_osc_enable_i,
  input wire logic high_speed_osc_enable_i,
  input wire logic [31:0] prdata_o,
  input wire logic internal_osc_run_o,
  input wire logic low_speed_osc_run_o,
  input wire logic high_speed_osc_run_o,
  input wire logic wake_internal_osc_on_o,
  input wire logic wake_select_internal_o,
  input wire logic [1:0] peripheral_clock_group_o,
  input wire logic peripheral_clock_on_o,
  input wire logic core_clock_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [3:0] gap;
  // cycles since the last core clock pulse
  always_ff @(posedge clock_i) begin
    if (rst_i || core_clock_enable_o) gap <= 4'h0;
    else if (ce_i) gap <= gap + 4'h1;
  end
  sequence wake_pulse;
    wake_internal_osc_on_o && wake_select_internal_o && internal_osc_run_o;
  endsequence
  sequence wake_over;
    !wake_internal_osc_on_o && !wake_select_internal_o;
  endsequence
  AST_LOW_RUN: assert property (ce_i && !sleep_i |=>
    low_speed_osc_run_o == $past(low_speed_osc_enable_i)) else $error("low run wrong");
  AST_HIGH_RUN: assert property (ce_i && !sleep_i |=>
    high_speed_osc_run_o == $past(high_speed_osc_enable_i)) else $error("high run wrong");
  AST_INT_RUN: assert property (ce_i && !sleep_i && internal_osc_enable_i |=>
    internal_osc_run_o) else $error("internal run wrong");
  AST_WAKE: assert property (ce_i && $fell(sleep_i) |=> wake_pulse ##1 wake_over)
    else $error("wake pulse wrong");
  AST_WAKE_CAUSE: assert property (wake_select_internal_o |->
    $past(sleep_i, 2) && !$past(sleep_i)) else $error("wake without sleep exit");
  AST_PCLK_ON: assert property (peripheral_clock_on_o == (peripheral_clock_group_o == 2'h3))
    else $error("peripheral clock flag wrong");
  AST_UPPER_ZERO: assert property (prdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_GEAR_GAP: assert property (gap <= 4'h7)
    else $error("core clock gap too long");
endmodule
bind clock_gen_output_gating clock_gen_output_gating_monitor clock_gen_output_gating_monitor_inst (
  .clock_i, .rst_i, .ce_i, .sleep_i, .internal_osc_enable_i, .low_speed_osc_enable_i,
  .high_speed_osc_enable_i, .prdata_o, .internal_osc_run_o, .low_speed_osc_run_o,
  .high_speed_osc_run_o, .wake_internal_osc_on_o, .wake_select_internal_o,
  .peripheral_clock_group_o, .peripheral_clock_on_o, .core_clock_enable_o);

/* verification/clock_gen_output_gating_tb.sv */
// Purpose: self-checking bench for the clock generator block
// Assumes: zero wait-state APB slave, oscillators from the source model
// Notes: clock output rates are judged by counting pin and source rises
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module clock_gen_output_gating_tb;
  logic clock_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, sleep = 0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, cka, ckb, pon, cen;
  logic [2:0] osc, run, en = 3'b111, wk;
  logic [1:0] grp;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  clock_gen_output_gating clock_gen_output_gating_inst (.clock_i, .rst_i, .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'h1), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sleep_i(sleep), .internal_osc_enable_i(en[0]),
    .low_speed_osc_enable_i(en[1]), .high_speed_osc_enable_i(en[2]),
    .internal_osc_clk_i(osc[0]), .low_speed_osc_clk_i(osc[1]),
    .high_speed_osc_clk_i(osc[2]), .internal_osc_run_o(run[0]),
    .low_speed_osc_run_o(run[1]), .high_speed_osc_run_o(run[2]),
    .wake_internal_osc_on_o(wk[0]), .wake_select_internal_o(wk[1]),
    .clock_out_a_o(cka), .clock_out_b_o(ckb), .peripheral_clock_group_o(grp),
    .peripheral_clock_on_o(pon), .core_clock_enable_o(cen));
  osc_source_model osc_source_model_inst (.clock_i, .rst_i, .run_i(run), .osc_o(osc));
  // clock and hang guard
  initial forever #12.5 clock_i = !clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, d);
    int k;
    @(posedge clock_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clock_i); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, {24'h00_0000, e})
  endtask
  task automatic t_reset_vals();
    rdchk(clkgen_pkg::SLEEP_CTRL_ADDR, 8'h72);
    rdchk(clkgen_pkg::CLOCK_OUT_A_ADDR, 8'h00);
    rdchk(clkgen_pkg::CLOCK_OUT_B_ADDR, 8'h00);
    rdchk(clkgen_pkg::PCLK_GATE_ADDR, 8'h03);
    rdchk(clkgen_pkg::CORE_GEAR_ADDR, 8'h00);
    rdchk(32'h0000_0100, 8'h00);
    `CHK(err, 1'b1)
  endtask
  task automatic t_upper_bits();
    apb(1'b1, clkgen_pkg::CORE_GEAR_ADDR, 32'h0000_00ff);
    rdchk(clkgen_pkg::CORE_GEAR_ADDR, 8'h03);
    apb(1'b1, clkgen_pkg::CLOCK_OUT_A_ADDR, 32'h0000_00fe);
    rdchk(clkgen_pkg::CLOCK_OUT_A_ADDR, 8'h3c);
  endtask
  task automatic t_sleep();
    apb(1'b1, clkgen_pkg::SLEEP_CTRL_ADDR, 32'h0000_0020);
    rdchk(clkgen_pkg::SLEEP_CTRL_ADDR, 8'h22);
    @(posedge clock_i) sleep <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK(run, 3'b101)
    apb(1'b1, clkgen_pkg::SLEEP_CTRL_ADDR, 32'h0000_0050);
    repeat (3) @(posedge clock_i);
    `CHK(run, 3'b010)
    sleep <= 1'b0;
    repeat (3) @(posedge clock_i);
    `CHK(run, 3'b111)
  endtask
  // count pin and source rises over n cycles
  task automatic measure(input int ch, s, n, output int pr, sr);
    logic pp, sp, pn, sn;
    pr = 0; sr = 0; pp = 0; sp = 0;
    repeat (n) begin
      @(posedge clock_i);
      pn = ch ? ckb : cka;
      sn = (s < 3) ? osc[s] : 1'b0;
      pr += (pn && !pp);
      sr += (sn && !sp);
      pp = pn; sp = sn;
    end
  endtask
  task automatic t_outputs();
    int pr, sr, ex;
    logic [31:0] a;
    for (int ch = 0; ch < 2; ch++) begin
      a = ch ? clkgen_pkg::CLOCK_OUT_B_ADDR : clkgen_pkg::CLOCK_OUT_A_ADDR;
      // peripheral clock cut while channel B runs; only codes 0 and 3 are written
      // gate codes legal
      apb(1'b1, clkgen_pkg::PCLK_GATE_ADDR, ch ? 32'h0000_0000 : 32'h0000_0003);
      // the write lands at the access edge; look one edge later
      @(posedge clock_i);
      `CHK(pon, ch == 0)
      for (int s = 0; s < 4; s++) for (int d = 0; d < 3; d++) begin
        apb(1'b1, a, 32'(d * 16 + s * 4 + 1));
        repeat (30) @(posedge clock_i);
        measure(ch, s, 240, pr, sr);
        ex = (s == 1) ? sr : sr >> d;
        `CHK(pr >= ex - 1 && pr <= ex + 1 && (s < 3 || pr == 0), 1'b1)
      end
      apb(1'b1, a, 32'h0000_0008);
      repeat (20) @(posedge clock_i);
      measure(ch, 0, 100, pr, sr);
      `CHK({pr == 0, ch ? ckb : cka}, 2'b10)
    end
    apb(1'b1, clkgen_pkg::PCLK_GATE_ADDR, 32'h0000_0003);
    @(posedge clock_i);
    `CHK(grp, 2'h3)
  endtask
  task automatic t_gear();
    int c;
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, clkgen_pkg::CORE_GEAR_ADDR, 32'(g));
      repeat (4) @(posedge clock_i);
      c = 0;
      repeat (64) begin @(posedge clock_i); c += cen; end
      `CHK(c, 64 >> g)
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_upper_bits();
    t_sleep();
    t_outputs();
    t_gear();
    test_done();
  end
endmodule

/* verification/osc_source_model.sv */
// Purpose: oscillator model feeding sampled oscillator levels to the block
// Assumes: levels change on clock_i, each well below half its rate
// Notes: a stopped oscillator parks its line low
`timescale 1ns/1ps
module osc_source_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [2:0] run_i,
  output logic [2:0] osc_o
);
  int cnt[3];
  int half[3] = '{4, 6, 3};
  // free-running half-period counters, cleared while stopped
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_i || !run_i[i]) begin
        cnt[i] <= 0;
        osc_o[i] <= 1'b0;
      end else if (cnt[i] == half[i] - 1) begin
        cnt[i] <= 0;
        osc_o[i] <= !osc_o[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule
